/* src/plm_port_top.sv */
// port latch and match block with avalon-mm register slave
`timescale 1ns/100ps
`include "plm_map.svh"

// Functional notes
// - software write to port zero register loads latch, driving digital pins
// - reading port zero register returns sampled pin levels, never latch contents
// - match compares only pins whose mask bit is one
// - match bit zero compares against low, one against high
// - port one width is 8, 7 or 4; match ignores upper bits, port one pin read still returns all 8
module plm_port_top #(
	parameter int P1_WIDTH = 8
) (
	input  wire logic                         ref_clk_in,
	input  wire logic                         rst_in,
	input  wire logic [`PLM_ADDR_W-1:0]       avs_address_in,
	input  wire logic                         avs_read_in,
	input  wire logic                         avs_write_in,
	input  wire logic [`PLM_DATA_W-1:0]       avs_writedata_in,
	output logic      [`PLM_DATA_W-1:0]       avs_readdata_out,
	output logic                              avs_waitrequest_out,
	input  wire plm_pkg::plm_byte_t           port_zero_pins_in,
	output plm_pkg::plm_byte_t                port_zero_pins_out,
	output plm_pkg::plm_byte_t                port_zero_pins_oe_out,
	input  wire plm_pkg::plm_byte_t           port_one_pins_in,
	output logic                              port_match_out,
	output logic                              irq_out
);
	import plm_pkg::*;

	// ***********************************
	// address decode
	// ***********************************
	function automatic plm_sel_t decode(input logic [`PLM_ADDR_W-1:0] a);
		logic [7:0] idx;
		idx = a[`PLM_ADDR_W-1:`PLM_LANE_LO];
		if (a[`PLM_LANE_LO-1:0] != '0) begin
			return PLM_SEL_NONE;
		end
		unique case (idx)
			`PLM_IDX_P0_LATCH:   return PLM_SEL_P0_LATCH;
			`PLM_IDX_P0_DIGITAL: return PLM_SEL_P0_DIGITAL;
			`PLM_IDX_MATCH_VAL:  return PLM_SEL_MATCH_VAL;
			`PLM_IDX_MATCH_MASK: return PLM_SEL_MATCH_MASK;
			`PLM_IDX_P1_PINS:    return PLM_SEL_P1_PINS;
			`PLM_IDX_IRQ_STAT:   return PLM_SEL_IRQ_STAT;
			`PLM_IDX_IRQ_MASK:   return PLM_SEL_IRQ_MASK;
			default:             return PLM_SEL_NONE;
		endcase
	endfunction : decode

	function automatic logic [`PLM_DATA_W-1:0] widen(input plm_byte_t b);
		return {{(`PLM_DATA_W-`PLM_BYTE_W){1'b0}}, b};
	endfunction : widen

	plm_sel_t  sel;
	logic      acc_rd;
	logic      acc_wr;
	plm_byte_t wr_byte;
	plm_byte_t p0_latch_q;
	plm_byte_t p0_digital_q;
	plm_byte_t match_val_q;
	plm_byte_t match_mask_q;
	plm_byte_t p0_pins_q;
	plm_byte_t p1_pins_q;
	plm_byte_t irq_stat;
	plm_byte_t irq_mask;
	plm_byte_t irq_event;
	logic      irq_line;
	logic [`PLM_DATA_W-1:0] rd_d;

	plm_match_if mif ();

	assign sel     = decode(avs_address_in);
	assign wr_byte = avs_writedata_in[`PLM_BYTE_W-1:0];
	// read data and status clear share the first edge, so no event is lost
	assign acc_rd  = avs_read_in && avs_waitrequest_out;
	// write completes on the edge waitrequest is seen low
	assign acc_wr  = avs_write_in && !avs_waitrequest_out;

	// ***********************************
	// bus handshake, one wait cycle
	// ***********************************
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			avs_waitrequest_out <= 1'b1;
		end else if ((avs_read_in || avs_write_in) && avs_waitrequest_out) begin
			avs_waitrequest_out <= 1'b0;
		end else begin
			avs_waitrequest_out <= 1'b1;
		end
	end

	// ***********************************
	// pin sampling
	// ***********************************
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			p0_pins_q <= '0;
			p1_pins_q <= '0;
		end else begin
			p0_pins_q <= port_zero_pins_in;
			p1_pins_q <= port_one_pins_in;
		end
	end

	// ***********************************
	// port zero latch and drive
	// ***********************************
	// latch load
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			p0_latch_q <= `PLM_RST_P0_LATCH;
		end else if (acc_wr && sel == PLM_SEL_P0_LATCH) begin
			p0_latch_q <= wr_byte;
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			p0_digital_q <= `PLM_RST_P0_DIGITAL;
		end else if (acc_wr && sel == PLM_SEL_P0_DIGITAL) begin
			p0_digital_q <= wr_byte;
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			port_zero_pins_out    <= `PLM_RST_P0_LATCH;
			port_zero_pins_oe_out <= `PLM_RST_P0_DIGITAL;
		end else begin
			port_zero_pins_out    <= p0_latch_q;
			port_zero_pins_oe_out <= p0_digital_q;
		end
	end

	// ***********************************
	// match configuration
	// ***********************************
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			match_val_q <= `PLM_RST_MATCH_VAL;
		end else if (acc_wr && sel == PLM_SEL_MATCH_VAL) begin
			match_val_q <= wr_byte;
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			match_mask_q <= `PLM_RST_MATCH_MASK;
		end else if (acc_wr && sel == PLM_SEL_MATCH_MASK) begin
			match_mask_q <= wr_byte;
		end
	end

	assign mif.pins  = p1_pins_q;
	assign mif.value = match_val_q;
	assign mif.mask  = match_mask_q;

	plm_match #(
		.P1_WIDTH (P1_WIDTH)
	) u_match (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.mif        (mif)
	);

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			port_match_out <= 1'b0;
		end else begin
			port_match_out <= mif.mismatch;
		end
	end

	// ***********************************
	// interrupt
	// ***********************************
	always_comb begin
		irq_event = '0;
		irq_event[`PLM_IRQ_MATCH_BIT] = mif.mismatch;
	end

	plm_irq u_irq (
		.ref_clk_in   (ref_clk_in),
		.rst_in       (rst_in),
		.event_in     (irq_event),
		.stat_rd_in   (acc_rd && sel == PLM_SEL_IRQ_STAT),
		.mask_wr_in   (acc_wr && sel == PLM_SEL_IRQ_MASK),
		.mask_data_in (wr_byte),
		.stat_out     (irq_stat),
		.mask_out     (irq_mask),
		.irq_out      (irq_line)
	);

	assign irq_out = irq_line;

	// ***********************************
	// read data
	// ***********************************
	always_comb begin
		rd_d = '0;
		unique case (sel)
			PLM_SEL_P0_LATCH:   rd_d = widen(p0_pins_q);
			PLM_SEL_P0_DIGITAL: rd_d = widen(p0_digital_q);
			PLM_SEL_MATCH_VAL:  rd_d = widen(match_val_q);
			PLM_SEL_MATCH_MASK: rd_d = widen(match_mask_q);
			PLM_SEL_P1_PINS:    rd_d = widen(p1_pins_q);
			PLM_SEL_IRQ_STAT:   rd_d = widen(irq_stat);
			PLM_SEL_IRQ_MASK:   rd_d = widen(irq_mask);
			PLM_SEL_NONE:       rd_d = '0;
		endcase
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			avs_readdata_out <= '0;
		end else if (acc_rd) begin
			avs_readdata_out <= rd_d;
		end
	end
endmodule : plm_port_top

/* src/plm_map.svh */
// register map, reset values and bus constants of the port latch and match block
`ifndef PLM_MAP_SVH
`define PLM_MAP_SVH

// register indexes; byte address is four times the index
`define PLM_IDX_P0_LATCH   8'h80
`define PLM_IDX_P0_DIGITAL 8'h81
`define PLM_IDX_MATCH_VAL  8'hED
`define PLM_IDX_MATCH_MASK 8'hEE
`define PLM_IDX_P1_PINS    8'hEF
`define PLM_IDX_IRQ_STAT   8'hF0
`define PLM_IDX_IRQ_MASK   8'hF1

// bus geometry
`define PLM_ADDR_W         10
`define PLM_DATA_W         32
`define PLM_LANE_LO        2
`define PLM_BYTE_W         8

// reset values
`define PLM_RST_P0_LATCH   8'hFF
`define PLM_RST_P0_DIGITAL 8'hFF
`define PLM_RST_MATCH_VAL  8'hFF
`define PLM_RST_MATCH_MASK 8'h00
`define PLM_RST_IRQ        8'h00

// status field positions
`define PLM_IRQ_MATCH_BIT  0

`endif

/* src/plm_pkg.sv */
// shared types of the port latch and match block
package plm_pkg;

	typedef logic [7:0] plm_byte_t;

	typedef enum logic [2:0] {
		PLM_SEL_NONE,
		PLM_SEL_P0_LATCH,
		PLM_SEL_P0_DIGITAL,
		PLM_SEL_MATCH_VAL,
		PLM_SEL_MATCH_MASK,
		PLM_SEL_P1_PINS,
		PLM_SEL_IRQ_STAT,
		PLM_SEL_IRQ_MASK
	} plm_sel_t;

endpackage : plm_pkg

/* src/plm_match_if.sv */
// carrier between register file and match comparator
`timescale 1ns/100ps
interface plm_match_if;
	import plm_pkg::*;
	plm_byte_t pins;
	plm_byte_t value;
	plm_byte_t mask;
	logic      mismatch;

	modport regs (output pins, output value, output mask, input mismatch);
	modport cmp  (input pins, input value, input mask, output mismatch);
endinterface : plm_match_if

/* src/plm_match.sv */
// port one match comparator
`timescale 1ns/100ps
module plm_match #(
	parameter int P1_WIDTH = 8
) (
	input  wire logic    ref_clk_in,
	input  wire logic    rst_in,
	plm_match_if.cmp     mif
);
	import plm_pkg::*;

	// ***********************************
	// implemented pin mask
	// ***********************************
	function automatic plm_byte_t impl_mask(input int width);
		plm_byte_t m;
		m = '0;
		for (int i = 0; i < 8; i++) begin
			if (i < width) begin
				m[i] = 1'b1;
			end
		end
		return m;
	endfunction : impl_mask

	localparam plm_byte_t IMPL = impl_mask(P1_WIDTH);

	plm_byte_t enabled;
	plm_byte_t differ;

	assign enabled = mif.mask & IMPL;
	assign differ  = (mif.pins ^ mif.value) & enabled;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			mif.mismatch <= 1'b0;
		end else begin
			mif.mismatch <= |differ;
		end
	end
endmodule : plm_match

/* src/plm_irq.sv */
// sticky status, mask and interrupt line
`timescale 1ns/100ps
`include "plm_map.svh"
module plm_irq (
	input  wire logic          ref_clk_in,
	input  wire logic          rst_in,
	input  wire plm_pkg::plm_byte_t event_in,
	input  wire logic          stat_rd_in,
	input  wire logic          mask_wr_in,
	input  wire plm_pkg::plm_byte_t mask_data_in,
	output plm_pkg::plm_byte_t stat_out,
	output plm_pkg::plm_byte_t mask_out,
	output logic               irq_out
);
	import plm_pkg::*;

	// ***********************************
	// sticky status, set beats read clear
	// ***********************************
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			stat_out <= `PLM_RST_IRQ;
		end else if (stat_rd_in) begin
			stat_out <= event_in;
		end else begin
			stat_out <= stat_out | event_in;
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			mask_out <= `PLM_RST_IRQ;
		end else if (mask_wr_in) begin
			mask_out <= mask_data_in;
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(stat_out & mask_out);
		end
	end
endmodule : plm_irq

/* verif/plm_pins_model.sv */
// outside circuitry on the two port pin groups
`timescale 1ns/100ps
module plm_pins_model (
	input  wire plm_pkg::plm_byte_t drv_in,
	input  wire plm_pkg::plm_byte_t oe_in,
	input  wire plm_pkg::plm_byte_t ext_zero_in,
	input  wire plm_pkg::plm_byte_t ext_one_in,
	output plm_pkg::plm_byte_t      pin_zero_out,
	output plm_pkg::plm_byte_t      pin_one_out
);
	import plm_pkg::*;
	// driven bits follow the latch, released bits the outside source
	assign pin_zero_out = (drv_in & oe_in) | (ext_zero_in & ~oe_in);
	assign pin_one_out  = ext_one_in;
endmodule : plm_pins_model

/* verif/plm_port_chk.sv */
// port level assertions of the port latch and match block
`timescale 1ns/100ps
`include "plm_map.svh"
module plm_port_chk #(
	parameter int P1_WIDTH = 8
) (
	input wire logic                   ref_clk_in,
	input wire logic                   rst_in,
	input wire logic [`PLM_ADDR_W-1:0] avs_address_in,
	input wire logic                   avs_read_in,
	input wire logic                   avs_write_in,
	input wire logic [`PLM_DATA_W-1:0] avs_writedata_in,
	input wire logic [`PLM_DATA_W-1:0] avs_readdata_out,
	input wire logic                   avs_waitrequest_out,
	input wire plm_pkg::plm_byte_t     port_zero_pins_in,
	input wire plm_pkg::plm_byte_t     port_zero_pins_out,
	input wire plm_pkg::plm_byte_t     port_one_pins_in,
	input wire logic                   port_match_out,
	input wire logic                   irq_out
);
	import plm_pkg::*;
	logic      wr_done;
	logic      rd_done;
	logic      mis;
	plm_byte_t val_q;
	plm_byte_t msk_q;
	plm_byte_t imk_q;
	assign wr_done = avs_write_in && !avs_waitrequest_out && avs_address_in[1:0] == 2'h0;
	assign rd_done = avs_read_in && !avs_waitrequest_out;
	assign mis = |((port_one_pins_in ^ val_q) & msk_q & plm_byte_t'((9'h001 << P1_WIDTH) - 9'h001));
	// shadow copies of match and interrupt mask registers
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			val_q <= `PLM_RST_MATCH_VAL;
			msk_q <= `PLM_RST_MATCH_MASK;
			imk_q <= `PLM_RST_IRQ;
		end else if (wr_done) begin
			if (avs_address_in[9:2] == `PLM_IDX_MATCH_VAL) val_q <= avs_writedata_in[7:0];
			if (avs_address_in[9:2] == `PLM_IDX_MATCH_MASK) msk_q <= avs_writedata_in[7:0];
			if (avs_address_in[9:2] == `PLM_IDX_IRQ_MASK) imk_q <= avs_writedata_in[7:0];
		end
	end
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	a_latch_drive: assert property (
		wr_done && avs_address_in[9:2] == `PLM_IDX_P0_LATCH |-> ##2
		port_zero_pins_out == $past(avs_writedata_in[7:0], 2)) else $error("latch not driven");
	a_read_pins: assert property (
		rd_done && avs_address_in == {`PLM_IDX_P0_LATCH, 2'h0} |->
		avs_readdata_out[7:0] == $past(port_zero_pins_in, 2)) else $error("pin read wrong");
	a_match_set: assert property (mis [*5] |-> port_match_out) else $error("match missing");
	a_match_clear: assert property ((!mis) [*5] |-> !port_match_out) else $error("false match");
	a_irq_raise: assert property (
		(port_match_out && imk_q[0]) [*4] |-> irq_out) else $error("irq missing");
	a_irq_masked: assert property ((!imk_q[0]) [*2] |-> !irq_out) else $error("irq unmasked");
endmodule : plm_port_chk
bind plm_port_top plm_port_chk #(.P1_WIDTH(P1_WIDTH)) u_chk (.ref_clk_in, .rst_in, .avs_address_in,
	.avs_read_in, .avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out,
	.port_zero_pins_in, .port_zero_pins_out, .port_one_pins_in, .port_match_out, .irq_out);

/* verif/tb.sv */
// self-checking bench of the port latch and match block
`timescale 1ns/100ps
`include "plm_map.svh"
module tb;
	import plm_pkg::*;
	localparam int        W  = 7;
	localparam plm_byte_t WM = plm_byte_t'((9'h001 << W) - 9'h001);
	logic                   ref_clk_in, rst_in, rd, wr, wq, mo, irq;
	logic                   xp = 1'b0;
	logic [`PLM_ADDR_W-1:0] adr;
	logic [31:0]            wd, rdat;
	plm_byte_t              p0i, p0o, oe, p1i, ez, e1, v, m, p;
	integer                 seed = 41, n_mismatch = 0, comparisons = 0;
	logic [31:0]            q[$];
	plm_port_top #(.P1_WIDTH(W)) dut (.ref_clk_in, .rst_in, .avs_address_in(adr), .avs_read_in(rd),
		.avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdat), .avs_waitrequest_out(wq),
		.port_zero_pins_in(p0i), .port_zero_pins_out(p0o), .port_zero_pins_oe_out(oe),
		.port_one_pins_in(p1i), .port_match_out(mo), .irq_out(irq));
	plm_pins_model pins (.drv_in(p0o), .oe_in(oe), .ext_zero_in(ez), .ext_one_in(e1),
		.pin_zero_out(p0i), .pin_one_out(p1i));
	task chk(input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk
	task test_done;
		$display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : test_done
	task bus(input plm_byte_t i, input logic w, input plm_byte_t d);
		adr <= {i, 2'h0};
		wd <= {24'h0, d};
		rd <= !w;
		wr <= w;
		do @(posedge ref_clk_in); while (wq !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge ref_clk_in);
	endtask : bus
	task rdx(input plm_byte_t i, input plm_byte_t e);
		q.push_back({24'h0, e});
		bus(i, 1'b0, 8'h00);
	endtask : rdx
	initial begin
		ref_clk_in = 1'b0;
		forever #20 ref_clk_in = ~ref_clk_in;
	end
	initial begin
		repeat (20000) @(posedge ref_clk_in);
		n_mismatch++;
		test_done;
	end
	// read results against oldest note
	always @(posedge ref_clk_in) if (rd && wq === 1'b0) chk(q.pop_front(), rdat);
	initial begin
		rst_in = 1'b1;
		rd = 1'b0;
		wr = 1'b0;
		adr = '0;
		wd = '0;
		ez = 8'h00;
		e1 = 8'h00;
		repeat (16) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		@(posedge ref_clk_in);
		chk(`PLM_RST_P0_LATCH, p0o);
		chk(`PLM_RST_P0_DIGITAL, oe);
		rdx(`PLM_IDX_MATCH_VAL, `PLM_RST_MATCH_VAL);
		rdx(`PLM_IDX_MATCH_MASK, `PLM_RST_MATCH_MASK);
		rdx(`PLM_IDX_IRQ_MASK, `PLM_RST_IRQ);
		rdx(8'h10, 8'h00);
		for (int k = 0; k < 6; k++) begin
			v = 8'($random(seed));
			m = 8'($random(seed));
			ez <= 8'($random(seed));
			bus(`PLM_IDX_P0_LATCH, 1'b1, v);
			bus(`PLM_IDX_P0_DIGITAL, 1'b1, m);
			@(posedge ref_clk_in);
			chk(v, p0o);
			chk(m, oe);
			rdx(`PLM_IDX_P0_LATCH, (v & m) | (ez & ~m));
		end
		bus(`PLM_IDX_IRQ_MASK, 1'b1, 8'h01);
		for (int k = 0; k < 16; k++) begin
			m = 8'($random(seed));
			v = 8'($random(seed));
			p = 8'($random(seed));
			bus(`PLM_IDX_MATCH_MASK, 1'b1, 8'h00);
			bus(`PLM_IDX_MATCH_VAL, 1'b1, v);
			e1 <= p;
			repeat (6) @(posedge ref_clk_in);
			rdx(`PLM_IDX_IRQ_STAT, {7'h00, xp});
			rdx(`PLM_IDX_P1_PINS, p);
			bus(`PLM_IDX_MATCH_MASK, 1'b1, m);
			xp = |((p ^ v) & m & WM);
			repeat (6) @(posedge ref_clk_in);
			chk(xp, mo);
			chk(xp, irq);
		end
		bus(`PLM_IDX_MATCH_MASK, 1'b1, 8'h01);
		bus(`PLM_IDX_MATCH_VAL, 1'b1, 8'h00);
		e1 <= 8'h01;
		repeat (6) @(posedge ref_clk_in);
		bus(`PLM_IDX_IRQ_MASK, 1'b1, 8'h00);
		e1 <= 8'h00;
		repeat (6) @(posedge ref_clk_in);
		chk(1'b0, mo);
		chk(1'b0, irq);
		rdx(`PLM_IDX_IRQ_STAT, 8'h01);
		rdx(`PLM_IDX_IRQ_STAT, 8'h00);
		test_done;
	end
endmodule : tb
